// [lcd_cmd_pkg.sv]
`default_nettype none
package lcd_cmd_pkg;

  // wishbone register map (byte addresses)
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] FRAME_OFS = 8'h08;

  // status register field positions
  localparam int ST_SUBADDR_POS = 0;
  localparam int ST_INBANK_POS = 2;
  localparam int ST_OUTBANK_POS = 3;
  localparam int ST_BLINKMODE_POS = 4;
  localparam int ST_BLINKRATE_POS = 5;
  localparam int ST_PRESCALE_POS = 7;
  localparam int ST_DRIVE_POS = 10;
  localparam int ST_ENABLE_POS = 12;
  localparam int ST_BIAS_POS = 13;
  localparam int ST_POINTER_POS = 14;
  localparam int ST_HWSUB_POS = 22;

  // opcode patterns and the number of fixed upper bits each one has
  localparam logic [5:0] DEVSEL_OP = 6'h38;
  localparam logic [5:0] BANKSEL_OP = 6'h3e;
  localparam logic [4:0] BLINK_OP = 5'h1e;
  localparam logic [4:0] PRESCALE_OP = 5'h1d;
  localparam logic [3:0] MODESET_OP = 4'hc;
  localparam logic [3:0] PTR_MSB_OP = 4'h0;
  localparam logic [3:0] PTR_LSB_OP = 4'h4;

  // control byte bit positions
  localparam int CHAIN_BIT = 7;
  localparam int TARGET_BIT = 6;

  // drive mode encodings
  localparam logic [1:0] DRIVE_STATIC = 2'h1;
  localparam logic [1:0] DRIVE_MUX2 = 2'h2;
  localparam logic [1:0] DRIVE_MUX3 = 2'h3;
  localparam logic [1:0] DRIVE_MUX4 = 2'h0;

  // values after reset
  localparam logic [1:0] SUBADDR_RST = 2'h0;
  localparam logic BANK_RST = 1'b0;
  localparam logic BLINKMODE_RST = 1'b0;
  localparam logic [1:0] BLINKRATE_RST = 2'h0;
  localparam logic [2:0] PRESCALE_RST = 3'h3;
  localparam logic [1:0] DRIVE_RST = DRIVE_MUX4;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic BIAS_RST = 1'b0;
  localparam logic [7:0] POINTER_RST = 8'h00;

  // display ram has 160 addresses
  localparam logic [7:0] RAM_LAST = 8'h9f;

  // ram addresses consumed by one data byte per drive mode
  localparam logic [7:0] STEP_STATIC = 8'h08;
  localparam logic [7:0] STEP_MUX2 = 8'h04;
  localparam logic [7:0] STEP_MUX3 = 8'h03;
  localparam logic [7:0] STEP_MUX4 = 8'h02;

  // frame rate = clk/24 * FRAME_NUM / denominator
  localparam int FRAME_BASE_DIV = 24;
  localparam logic [6:0] FRAME_NUM = 7'h40;
  localparam logic [6:0] FRAME_DEN_000 = 7'h50;
  localparam logic [6:0] FRAME_DEN_001 = 7'h4a;
  localparam logic [6:0] FRAME_DEN_010 = 7'h44;
  localparam logic [6:0] FRAME_DEN_011 = 7'h40;
  localparam logic [6:0] FRAME_DEN_100 = 7'h3c;
  localparam logic [6:0] FRAME_DEN_101 = 7'h38;
  localparam logic [6:0] FRAME_DEN_110 = 7'h35;
  localparam logic [6:0] FRAME_DEN_111 = 7'h40;
  localparam logic [6:0] FRAME_DEN_RST = FRAME_DEN_011;

  typedef enum logic [1:0] {
    EXPECT_CTRL = 2'b01,
    EXPECT_BYTE = 2'b10
  } parse_t;

endpackage
`default_nettype wire

// [lcd_command_status_logic.sv]
`timescale 1ns/1ns
`default_nettype none

module lcd_command_status_logic
  import lcd_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic xferStart,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic [1:0] hwSubaddrPin,
  output logic [1:0] subaddr,
  output logic inBank,
  output logic outBank,
  output logic blinkMode,
  output logic [1:0] blink_rate_field,
  output logic [2:0] prescale,
  output logic [6:0] frameDen,
  output logic [1:0] driveMode,
  output logic displayEnable,
  output logic biasHalf,
  output logic ramWe,
  output logic [7:0] ramAddr,
  output logic [7:0] ramData,
  output logic ramBank
);

  typedef struct packed {
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    parse_t parse;
    logic chain_flag;
    logic target_select_flag;
    logic [1:0] subaddr;
    logic inBank;
    logic outBank;
    logic blinkStored;
    logic blinkEff;
    logic [1:0] blinkRate;
    logic [2:0] prescale;
    logic [6:0] frameDen;
    logic [1:0] drive;
    logic enable;
    logic bias;
    logic [7:0] pointer;
    logic ramWe;
    logic [7:0] ramAddr;
    logic [7:0] ramData;
    logic ramBank;
    logic ack;
    logic [31:0] datO;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  logic busReq;
  logic cmdValid;
  logic [7:0] cmd;
  logic dataValid;
  logic lowMux;
  logic [7:0] step;
  logic [8:0] nextPtr;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.ramWe = 1'b0;
    q_nxt.ack = 1'b0;
    q_nxt.datO = 32'h0;
    // the first stage feeds only the second
    q_nxt.pinMeta = hwSubaddrPin;
    q_nxt.pinSync = q_r.pinMeta;

    // ack is held back while a link byte is taken, so a bus command never collides
    busReq = wbCyc && wbStb && !q_r.ack && !byteValid;
    cmdValid = 1'b0;
    cmd = 8'h00;
    dataValid = 1'b0;

    if (xferStart)
    begin
      q_nxt.parse = EXPECT_CTRL;
    end
    else if (byteValid)
    begin
      unique case (q_r.parse)
        EXPECT_CTRL:
        begin
          q_nxt.chain_flag = byteData[CHAIN_BIT];
          q_nxt.target_select_flag = byteData[TARGET_BIT];
          q_nxt.parse = EXPECT_BYTE;
        end
        EXPECT_BYTE:
        begin
          // chain clear: every remaining byte is of the same kind
          if (q_r.chain_flag)
          begin
            q_nxt.parse = EXPECT_CTRL;
          end
          if (q_r.target_select_flag)
          begin
            dataValid = 1'b1;
          end
          else
          begin
            cmdValid = 1'b1;
            cmd = byteData;
          end
        end
      endcase
    end

    if (busReq)
    begin
      q_nxt.ack = 1'b1;
      if (wbWe && wbAdr == CMD_OFS && wbSel[0])
      begin
        cmdValid = 1'b1;
        cmd = wbDatI[7:0];
      end
    end

    lowMux = (q_r.drive == DRIVE_MUX3) || (q_r.drive == DRIVE_MUX4);

    if (cmdValid)
    begin
      if (cmd[7:2] == DEVSEL_OP)
      begin
        q_nxt.subaddr = cmd[1:0];
      end
      else if (cmd[7:2] == BANKSEL_OP)
      begin
        if (!lowMux)
        begin
          q_nxt.inBank = cmd[1];
          q_nxt.outBank = cmd[0];
        end
      end
      else if (cmd[7:3] == BLINK_OP)
      begin
        q_nxt.blinkStored = cmd[2];
        q_nxt.blinkRate = cmd[1:0];
      end
      else if (cmd[7:3] == PRESCALE_OP)
      begin
        q_nxt.prescale = cmd[2:0];
      end
      else if (cmd[7:4] == MODESET_OP)
      begin
        q_nxt.enable = cmd[3];
        q_nxt.bias = cmd[2];
        q_nxt.drive = cmd[1:0];
      end
      else if (cmd[7:4] == PTR_MSB_OP)
      begin
        q_nxt.pointer = {cmd[3:0], q_r.pointer[3:0]};
      end
      else if (cmd[7:4] == PTR_LSB_OP)
      begin
        q_nxt.pointer = {q_r.pointer[7:4], cmd[3:0]};
      end
      // any other pattern falls through untouched
    end

    // a data byte covers a whole number of addresses in each drive mode
    unique case (q_r.drive)
      DRIVE_STATIC: step = STEP_STATIC;
      DRIVE_MUX2: step = STEP_MUX2;
      DRIVE_MUX3: step = STEP_MUX3;
      DRIVE_MUX4: step = STEP_MUX4;
    endcase
    nextPtr = {1'b0, q_r.pointer} + {1'b0, step};

    if (dataValid)
    begin
      // only the device whose pins match the counter stores the byte
      if (q_r.subaddr == q_r.pinSync)
      begin
        q_nxt.ramWe = 1'b1;
        q_nxt.ramAddr = q_r.pointer;
        q_nxt.ramData = byteData;
        q_nxt.ramBank = lowMux ? BANK_RST : q_r.inBank;
      end
      // running off the end carries into the next device's subaddress
      if (nextPtr > {1'b0, RAM_LAST})
      begin
        q_nxt.pointer = POINTER_RST;
        q_nxt.subaddr = q_r.subaddr + 2'h1;
      end
      else
      begin
        q_nxt.pointer = nextPtr[7:0];
      end
    end

    // the bank-based modes cannot alternate banks in 1:3 or 1:4
    q_nxt.blinkEff = ((q_nxt.drive == DRIVE_MUX3) || (q_nxt.drive == DRIVE_MUX4)) ?
      1'b0 : q_nxt.blinkStored;

    unique case (q_nxt.prescale)
      3'h0: q_nxt.frameDen = FRAME_DEN_000;
      3'h1: q_nxt.frameDen = FRAME_DEN_001;
      3'h2: q_nxt.frameDen = FRAME_DEN_010;
      3'h3: q_nxt.frameDen = FRAME_DEN_011;
      3'h4: q_nxt.frameDen = FRAME_DEN_100;
      3'h5: q_nxt.frameDen = FRAME_DEN_101;
      3'h6: q_nxt.frameDen = FRAME_DEN_110;
      3'h7: q_nxt.frameDen = FRAME_DEN_111;
    endcase

    if (busReq && !wbWe)
    begin
      if (wbAdr == STATUS_OFS)
      begin
        q_nxt.datO[ST_SUBADDR_POS +: 2] = q_r.subaddr;
        q_nxt.datO[ST_INBANK_POS] = q_r.inBank;
        q_nxt.datO[ST_OUTBANK_POS] = q_r.outBank;
        q_nxt.datO[ST_BLINKMODE_POS] = q_r.blinkEff;
        q_nxt.datO[ST_BLINKRATE_POS +: 2] = q_r.blinkRate;
        q_nxt.datO[ST_PRESCALE_POS +: 3] = q_r.prescale;
        q_nxt.datO[ST_DRIVE_POS +: 2] = q_r.drive;
        q_nxt.datO[ST_ENABLE_POS] = q_r.enable;
        q_nxt.datO[ST_BIAS_POS] = q_r.bias;
        q_nxt.datO[ST_POINTER_POS +: 8] = q_r.pointer;
        q_nxt.datO[ST_HWSUB_POS +: 2] = q_r.pinSync;
      end
      else if (wbAdr == FRAME_OFS)
      begin
        q_nxt.datO[6:0] = q_r.frameDen;
        q_nxt.datO[14:8] = FRAME_NUM;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q_r <= '0;
      q_r.parse <= EXPECT_CTRL;
      q_r.subaddr <= SUBADDR_RST;
      q_r.inBank <= BANK_RST;
      q_r.outBank <= BANK_RST;
      q_r.blinkStored <= BLINKMODE_RST;
      q_r.blinkEff <= BLINKMODE_RST;
      q_r.blinkRate <= BLINKRATE_RST;
      q_r.prescale <= PRESCALE_RST;
      q_r.frameDen <= FRAME_DEN_RST;
      q_r.drive <= DRIVE_RST;
      q_r.enable <= ENABLE_RST;
      q_r.bias <= BIAS_RST;
      q_r.pointer <= POINTER_RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign wbDatO = q_r.datO;
  assign wbAck = q_r.ack;
  assign subaddr = q_r.subaddr;
  assign inBank = q_r.inBank;
  assign outBank = q_r.outBank;
  assign blinkMode = q_r.blinkEff;
  assign blink_rate_field = q_r.blinkRate;
  assign prescale = q_r.prescale;
  assign frameDen = q_r.frameDen;
  assign driveMode = q_r.drive;
  assign displayEnable = q_r.enable;
  assign biasHalf = q_r.bias;
  assign ramWe = q_r.ramWe;
  assign ramAddr = q_r.ramAddr;
  assign ramData = q_r.ramData;
  assign ramBank = q_r.ramBank;

endmodule

`default_nettype wire

// [lcd_cmd_props.sv]
`timescale 1ns/1ns
`default_nettype none
module lcd_cmd_props
  import lcd_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic wbAck,
  input wire logic xferStart,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic [1:0] subaddr,
  input wire logic inBank,
  input wire logic outBank,
  input wire logic blinkMode,
  input wire logic [1:0] blink_rate_field,
  input wire logic [2:0] prescale,
  input wire logic [6:0] frameDen,
  input wire logic [1:0] driveMode
);
  localparam logic [6:0] den [8] = '{7'h50, 7'h4a, 7'h44, 7'h40, 7'h3c, 7'h38, 7'h35, 7'h40};
  logic ctl_r;
  logic kind_r;
  logic chain_r;
  wire logic lnk = byteValid && !xferStart;
  // a bus command is only taken when no link byte competes for the edge
  wire logic cmdV = (lnk && !ctl_r && !kind_r)
    || (wbCyc && wbStb && wbWe && !wbAck && !byteValid && wbAdr == CMD_OFS && wbSel[0]);
  wire logic [7:0] cmd = lnk ? byteData : wbDatI[7:0];
  wire logic bankOk = driveMode[1] ^ driveMode[0];
  wire logic known = cmd[7:2] == 6'h38 || cmd[7:2] == 6'h3e || cmd[7:3] == 5'h1e || cmd[7:3] == 5'h1d
    || cmd[7:4] == 4'hc || cmd[7:4] == 4'h0 || cmd[7:4] == 4'h4;
  always_ff @(posedge clk)
  begin
    if (sys_rst || xferStart)
    begin
      ctl_r <= 1'b1;
      kind_r <= 1'b1;
    end
    else if (lnk)
    begin
      ctl_r <= ctl_r ? 1'b0 : chain_r;
      if (ctl_r)
      begin
        kind_r <= byteData[6];
        chain_r <= byteData[7];
      end
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_reset_vals:
    assert property ($fell(sys_rst) |-> subaddr == 2'h0 && prescale == 3'h3 && driveMode == 2'h0)
    else $error("fields not reset");
  chk_devsel_load:
    assert property (cmdV && cmd[7:2] == 6'h38 |=> subaddr == $past(cmd[1:0])) else $error("bad subaddr");
  chk_bank_load:
    assert property (cmdV && cmd[7:2] == 6'h3e && bankOk |=> {inBank, outBank} == $past(cmd[1:0]))
    else $error("bank not loaded");
  chk_bank_ignore:
    assert property (cmdV && cmd[7:2] == 6'h3e && !bankOk |=> $stable({inBank, outBank}))
    else $error("bank changed");
  chk_blink_load:
    assert property (cmdV && cmd[7:3] == 5'h1e |=> blink_rate_field == $past(cmd[1:0])
      && blinkMode == ($past(cmd[2]) && bankOk)) else $error("bad blink");
  chk_blink_normal:
    assert property (!bankOk && $stable(driveMode) |-> !blinkMode) else $error("alternate blink in 1:3/1:4");
  chk_prescale_load:
    assert property (cmdV && cmd[7:3] == 5'h1d |=> prescale == $past(cmd[2:0])) else $error("bad prescale");
  chk_frame_den:
    assert property (frameDen == den[prescale]) else $error("bad frame divider");
  chk_mode_load:
    assert property (cmdV && cmd[7:4] == 4'hc |=> driveMode == $past(cmd[1:0])) else $error("bad drive mode");
  chk_unknown_hold:
    assert property (cmdV && !known |=> $stable({subaddr, inBank, outBank, blinkMode, blink_rate_field, prescale,
      driveMode})) else $error("unknown command acted");
endmodule
bind lcd_command_status_logic lcd_cmd_props lcd_cmd_props_i (.*);
`default_nettype wire

// [lcd_byte_source.sv]
`timescale 1ns/1ns
`default_nettype none
module lcd_byte_source (
  input wire logic clk,
  output var logic xferStart,
  output var logic byteValid,
  output var logic [7:0] byteData
);
  initial {xferStart, byteValid, byteData} = 10'h0;
  // every transfer opens with a control byte
  task automatic start();
    xferStart <= 1'b1;
    @(posedge clk);
    xferStart <= 1'b0;
  endtask
  // released data shows the inverse so a late sample cannot match by luck
  task automatic put(input logic [7:0] b);
    byteValid <= 1'b1;
    byteData <= b;
    @(posedge clk);
    byteValid <= 1'b0;
    byteData <= ~b;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [lcd_command_status_logic_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module lcd_command_status_logic_tb
  import lcd_cmd_pkg::*;
;
  logic clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, xferStart, byteValid, inBank, outBank, blinkMode;
  logic displayEnable, biasHalf, ramWe, ramBank, bvD, ib, ob, bm, en, bi;
  logic [1:0] hwSubaddrPin, subaddr, blink_rate_field, driveMode, sa, dm, br, pin;
  logic [2:0] prescale, ps;
  logic [3:0] wbSel;
  logic [6:0] frameDen;
  logic [7:0] wbAdr, byteData, ramAddr, ramData, ptr;
  logic [31:0] wbDatI, wbDatO, r;
  logic [31:0] fq[$], dq[$], rq[$];
  int seed, errors, total_checks;
  logic [6:0] den [8] = '{7'h50, 7'h4a, 7'h44, 7'h40, 7'h3c, 7'h38, 7'h35, 7'h40};
  logic [7:0] stp [4] = '{8'h02, 8'h08, 8'h04, 8'h03};
  logic [9:0] seq [13] = '{10'h080, 10'h1c9, 10'h080, 10'h109, 10'h080, 10'h14c, 10'h080, 10'h1fe,
    10'h0c0, 10'h2a5, 10'h040, 10'h25a, 10'h2c3};
  wire logic [31:0] flds = 32'({subaddr, inBank, outBank, blinkMode, blink_rate_field, prescale, frameDen, driveMode,
    displayEnable, biasHalf});
  lcd_command_status_logic lcd_command_status_logic_i (.*);
  lcd_byte_source lcd_byte_source_i (.*);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] fields();
    return 32'({sa, ib, ob, bm & (dm[1] ^ dm[0]), br, ps, den[ps], dm, en, bi});
  endfunction
  function automatic logic [31:0] status();
    return {8'h00, pin, ptr, bi, en, dm, ps, br, bm & (dm[1] ^ dm[0]), ob, ib, sa};
  endfunction
  function automatic logic [31:0] frame();
    return {17'h0, 7'h40, 1'b0, den[ps]};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_fields();
    cmp(flds, fq.size() ? fq.pop_front() : 32'hx);
  endtask
  task automatic cmp_read();
    cmp(wbDatO, dq.size() ? dq.pop_front() : 32'hx);
  endtask
  task automatic cmp_ram();
    cmp(32'({ramAddr, ramData, ramBank}), rq.size() ? rq.pop_front() : 32'hx);
  endtask
  task automatic exec(input logic [7:0] c);
    if (c[7:2] == 6'h38) sa = c[1:0];
    else if (c[7:2] == 6'h3e && dm[1] != dm[0]) {ib, ob} = c[1:0];
    else if (c[7:3] == 5'h1e) {bm, br} = c[2:0];
    else if (c[7:3] == 5'h1d) ps = c[2:0];
    else if (c[7:4] == 4'hc) {en, bi, dm} = c[3:0];
    else if (c[7:4] == 4'h0) ptr[7:4] = c[3:0];
    else if (c[7:4] == 4'h4) ptr[3:0] = c[3:0];
  endtask
  task automatic dat(input logic [7:0] d);
    if (sa == pin) rq.push_back(32'({ptr, d, ib & (dm[1] ^ dm[0])}));
    // nine bits so a pointer loaded past the end cannot wrap unnoticed
    if ({1'b0, ptr} + {1'b0, stp[dm]} > 9'h09f)
    begin
      ptr = 8'h00;
      sa = sa + 2'h1;
    end
    else
    begin
      ptr = ptr + stp[dm];
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
    input logic [31:0] e);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDatI <= d;
    if (w && a == CMD_OFS && s[0]) exec(d[7:0]);
    fq.push_back(fields());
    dq.push_back(e);
    do
      @(posedge clk);
    while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic lnk(input logic [7:0] b, input logic [1:0] k);
    if (k == 2'h1) exec(b);
    if (k == 2'h2) dat(b);
    fq.push_back(fields());
    lcd_byte_source_i.put(b);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (bvD || wbAck === 1'b1) cmp_fields();
    if (wbAck === 1'b1) cmp_read();
    if (ramWe === 1'b1) cmp_ram();
    bvD <= byteValid && !xferStart;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial
  begin
    seed = 32'hb44e;
    sys_rst = 1'b1;
    bvD = 1'b0;
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI, hwSubaddrPin} = 0;
    {sa, ib, ob, bm, br, dm, en, bi, ptr, pin, errors, total_checks} = 0;
    ps = 3'h3;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    wb(1'b0, STATUS_OFS, 4'hf, 32'h0, status());
    lcd_byte_source_i.start();
    lnk(8'h00, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      lnk({5'h19, i[2:0]}, 2'h1);
      lnk({6'h3e, i[1:0]}, 2'h1);
      lnk({5'h1e, i[2:0]}, 2'h1);
      lnk({6'h38, i[1:0]}, 2'h1);
      wb(1'b1, CMD_OFS, 4'h1, {24'h0, 5'h1d, i[2:0]}, 32'h0);
      wb(1'b0, FRAME_OFS, 4'hf, 32'h0, frame());
    end
    repeat (60)
    begin
      r = $random(seed);
      if (r[31]) wb(1'b1, CMD_OFS, r[11:8], r, 32'h0);
      else lnk(r[7:0], 2'h1);
      wb(1'b0, STATUS_OFS, 4'hf, 32'h0, status());
    end
    wb(1'b1, STATUS_OFS, 4'hf, 32'he1, 32'h0);
    wb(1'b1, 8'h0c, 4'hf, 32'he1, 32'h0);
    wb(1'b0, 8'h0c, 4'hf, 32'h0, 32'h0);
    pin = sa;
    hwSubaddrPin <= pin;
    lcd_byte_source_i.start();
    foreach (seq[j]) lnk(seq[j][7:0], seq[j][9:8]);
    wb(1'b0, STATUS_OFS, 4'hf, 32'h0, status());
    cmp(32'(rq.size()), 32'h0);
    cmp(32'(fq.size() + dq.size()), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
